/* design/hsc_pkg.sv */
// constants shared by both ends of the humidity sensor command link
// assumes a 40 MHz system clock on both ends and an open-drain two-wire bus
package hsc_pkg;
    // bus address and command codes
    localparam logic [6:0] HSC_ADDR = 7'h38;
    localparam logic [7:0] CMD_INIT = 8'hbe;
    localparam logic [7:0] CMD_MEAS = 8'hac;
    localparam logic [7:0] INIT_P0 = 8'h08;
    localparam logic [7:0] INIT_P1 = 8'h00;
    localparam logic [7:0] MEAS_P0 = 8'h33;
    localparam logic [7:0] MEAS_P1 = 8'h00;
    // timing
    localparam int CLK_NS = 25;
    localparam int SLEEP_MS = 20;
    localparam int PWR_MS = 40;
    localparam int MEAS_MS = 75;
    localparam int SCL_KHZ = 100;
    localparam int SLEEP_CYC = SLEEP_MS * 1_000_000 / CLK_NS;
    localparam int PWR_CYC = (PWR_MS * 1_000_000 + CLK_NS - 1) / CLK_NS;
    localparam int MEAS_CYC = MEAS_MS * 1_000_000 / CLK_NS;
    localparam int QTR_CYC = (1_000_000 / SCL_KHZ + 4 * CLK_NS - 1) / (4 * CLK_NS);
    // status byte fields
    localparam int ST_BUSY = 7;
    localparam int ST_MODE = 5;
    localparam int ST_INTEG = 4;
    localparam int ST_CAL = 3;
    // host transfer lengths (bytes after the address)
    localparam logic [2:0] WR_LAST = 3'h3;
    localparam logic [2:0] STAT_LAST = 3'h1;
    localparam logic [2:0] READ_LAST = 3'h7;
    // host register map
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_DATA0 = 8'h08;
    localparam logic [7:0] REG_DATA1 = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_CLR = 8'h14;
    localparam logic [7:0] REG_IRQ_EN = 8'h18;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_NAK = 1;
    typedef enum logic [1:0] {
        OP_STATUS = 2'b00,
        OP_INIT = 2'b01,
        OP_MEAS = 2'b10,
        OP_READ = 2'b11
    } hsc_op_t;
endpackage

/* design/hsc_if.sv */
// two-wire link between the sensor port and its controller
// assumes open-drain wires with pull-ups; a driver only ever pulls low
`timescale 1ns/100ps
interface hsc_if;
    logic scl_o_host;
    logic scl_oe_host;
    logic sda_o_host;
    logic sda_oe_host;
    logic sda_o_dev;
    logic sda_oe_dev;
    logic scl;
    logic sda;
    assign scl = scl_oe_host ? scl_o_host : 1'b1;
    assign sda = (sda_oe_host ? sda_o_host : 1'b1) & (sda_oe_dev ? sda_o_dev : 1'b1);
    modport host (output scl_o_host, output scl_oe_host, output sda_o_host,
        output sda_oe_host, input scl, input sda);
    modport dev (output sda_o_dev, output sda_oe_dev, input scl, input sda);
endinterface

/* design/hsc_dev.sv */
// sensor end of the link: slave port, command decode, status byte
// assumes scl and sda arrive asynchronously; the sensing core is outside
//
// Contract
// - first byte: address 0x38 plus direction bit
// - drive ack low after eighth falling clock
// - command 0xbe starts initialization
// - command 0xac starts a measurement
// - host waits for measurement end before reading
// - status bit 7 is busy
// - status bit 4 flags integrity failure
// - status bit 3 calibrated, bits 2:0 reserved
// - sleep reached within 20 ms of power
// - start condition marks the bus busy
// - stop condition marks the bus idle
// - init command followed by 0x08, 0x00
// - measure command followed by 0x33, 0x00
// - host waits 75 ms, then reads seven bytes
// - host waits 40 ms, checks calibration first
`timescale 1ns/100ps
module hsc_dev
    import hsc_pkg::*;
#(
    parameter int SLEEP_CYCLES = SLEEP_CYC,
    parameter int MEAS_CYCLES = MEAS_CYC
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    hsc_if.dev bus,
    input wire logic [1:0] mode_in,
    input wire logic integ_fail_in,
    input wire logic [47:0] result_in,
    output logic ready_out,
    output logic busy_out,
    output logic bus_busy_out,
    output logic init_out,
    output logic meas_out
);
    typedef enum logic [2:0] {
        DS_IDLE = 3'b000,
        DS_RECV = 3'b001,
        DS_ACK = 3'b010,
        DS_SEND = 3'b011,
        DS_MACK = 3'b100
    } hsc_dstate_t;

    hsc_dstate_t state_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic scl_rise, scl_fall, start_seen, stop_seen, load_now;
    logic [31:0] por_q;
    logic ready_q, bus_busy_q;
    logic [7:0] sh_q, tx_q, wbyte_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q, widx_q;
    logic adr_q, rd_q, nak_q, got_q, sda_oe_q;
    logic busy_q, cal_q, init_q, meas_q;
    logic [31:0] mcnt_q;
    logic [47:0] result_q;
    logic [7:0] status_byte, next_byte;

    function automatic logic [7:0] read_byte(input logic [2:0] idx, input logic [7:0] st,
            input logic [47:0] res);
        logic [7:0] b;
        b = st;
        case (idx)
            3'h1: b = res[47:40];
            3'h2: b = res[39:32];
            3'h3: b = res[31:24];
            3'h4: b = res[23:16];
            3'h5: b = res[15:8];
            3'h6: b = res[7:0];
            default: b = st;
        endcase
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus condition detection

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
        end else begin
            {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, bus.scl};
            {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, bus.sda};
        end
    end

    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            bus_busy_q <= 1'b0;
        end else if (start_seen) begin
            bus_busy_q <= 1'b1;
        end else if (stop_seen) begin
            bus_busy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power-up: the port stays deaf until sleep is reached

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            por_q <= 32'h0000_0000;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            if (por_q == 32'(SLEEP_CYCLES - 1)) begin
                ready_q <= 1'b1;
            end else begin
                por_q <= por_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte engine

    assign status_byte = {busy_q, mode_in, integ_fail_in, cal_q, 3'b000};
    assign next_byte = read_byte(idx_q, status_byte, result_q);
    assign load_now = scl_fall & ((state_q == DS_ACK & rd_q) | (state_q == DS_MACK & ~nak_q));

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_q <= DS_IDLE;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            wbyte_q <= 8'h00;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            widx_q <= 3'h0;
            adr_q <= 1'b0;
            rd_q <= 1'b0;
            nak_q <= 1'b0;
            got_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            got_q <= 1'b0;
            if (start_seen && ready_q) begin
                state_q <= DS_RECV;
                bit_q <= 4'h0;
                adr_q <= 1'b1;
                sda_oe_q <= 1'b0;
            end else if (stop_seen) begin
                state_q <= DS_IDLE;
                sda_oe_q <= 1'b0;
            end else if (load_now) begin
                // reads drive each bit just after the falling clock
                sda_oe_q <= ~next_byte[7];
                tx_q <= {next_byte[6:0], 1'b0};
                bit_q <= 4'h1;
                if (idx_q != 3'h6) begin
                    idx_q <= idx_q + 3'h1;
                end
                state_q <= DS_SEND;
            end else begin
                case (state_q)
                    DS_RECV: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda_s2_q};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            if (adr_q && sh_q[7:1] != HSC_ADDR) begin
                                state_q <= DS_IDLE;
                            end else begin
                                sda_oe_q <= 1'b1;
                                state_q <= DS_ACK;
                                if (adr_q) begin
                                    rd_q <= sh_q[0];
                                    idx_q <= 3'h0;
                                end else begin
                                    got_q <= 1'b1;
                                    wbyte_q <= sh_q;
                                    widx_q <= idx_q;
                                    if (idx_q != 3'h7) begin
                                        idx_q <= idx_q + 3'h1;
                                    end
                                end
                            end
                        end
                    end
                    DS_ACK: begin
                        if (scl_fall) begin
                            sda_oe_q <= 1'b0;
                            bit_q <= 4'h0;
                            adr_q <= 1'b0;
                            state_q <= DS_RECV;
                        end
                    end
                    DS_SEND: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                sda_oe_q <= 1'b0;
                                state_q <= DS_MACK;
                            end else begin
                                sda_oe_q <= ~tx_q[7];
                                tx_q <= {tx_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    DS_MACK: begin
                        if (scl_rise) begin
                            nak_q <= sda_s2_q;
                        end else if (scl_fall) begin
                            state_q <= DS_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command decode and measurement timer
    // parameter bytes are accepted but not checked: a wrong one cannot be refused
    // after the command byte has already been acknowledged

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            busy_q <= 1'b0;
            cal_q <= 1'b0;
            init_q <= 1'b0;
            meas_q <= 1'b0;
            mcnt_q <= 32'h0000_0000;
            result_q <= 48'h0000_0000_0000;
        end else begin
            init_q <= 1'b0;
            meas_q <= 1'b0;
            if (got_q && widx_q == 3'h0 && wbyte_q == CMD_INIT) begin
                cal_q <= 1'b1;
                init_q <= 1'b1;
            end
            if (got_q && widx_q == 3'h0 && wbyte_q == CMD_MEAS && !busy_q) begin
                busy_q <= 1'b1;
                meas_q <= 1'b1;
                mcnt_q <= 32'h0000_0000;
            end else if (busy_q) begin
                if (mcnt_q == 32'(MEAS_CYCLES - 1)) begin
                    busy_q <= 1'b0;
                    result_q <= result_in;
                end else begin
                    mcnt_q <= mcnt_q + 32'h0000_0001;
                end
            end
        end
    end

    assign bus.sda_o_dev = 1'b0;
    assign bus.sda_oe_dev = sda_oe_q;
    assign ready_out = ready_q;
    assign busy_out = busy_q;
    assign bus_busy_out = bus_busy_q;
    assign init_out = init_q;
    assign meas_out = meas_q;
endmodule

/* design/hsc_host.sv */
// controller end of the link: register port, transfer sequencer, interrupt
// assumes a single-cycle register master; scl is made here by a divider
`timescale 1ns/100ps
module hsc_host
    import hsc_pkg::*;
#(
    parameter int PWR_CYCLES = PWR_CYC,
    parameter int MEAS_CYCLES = MEAS_CYC
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    hsc_if.host bus,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_START = 2'b01,
        HS_BIT = 2'b10,
        HS_STOP = 2'b11
    } hsc_hstate_t;

    hsc_hstate_t state_q;
    hsc_op_t op_q;
    logic sda_s1_q, sda_s2_q;
    logic [1:0] ph_q;
    logic [15:0] qcnt_q;
    logic [2:0] k_q, last_k;
    logic [3:0] bit_q;
    logic [7:0] tx_q, rx_sh_q;
    logic [7:0] rx_q [0:6];
    logic smp_q, pend_q, nak_q, done_q, nak_ev_q, scl_oe_q, sda_oe_q, tick, is_rd, wr_b;
    logic [31:0] wait_q, rdata_q;
    logic [1:0] irq_st_q, irq_en_q, irq_ev;

    function automatic logic [7:0] tx_byte(input hsc_op_t op, input logic [2:0] k);
        logic [7:0] b;
        b = 8'h00;
        if (k == 3'h0) begin
            b = {HSC_ADDR, op == OP_STATUS || op == OP_READ};
        end else if (op == OP_INIT) begin
            b = (k == 3'h1) ? CMD_INIT : (k == 3'h2) ? INIT_P0 : INIT_P1;
        end else if (op == OP_MEAS) begin
            b = (k == 3'h1) ? CMD_MEAS : (k == 3'h2) ? MEAS_P0 : MEAS_P1;
        end
        return b;
    endfunction

    assign is_rd = op_q == OP_STATUS || op_q == OP_READ;
    assign wr_b = k_q == 3'h0 || !is_rd;
    assign last_k = (op_q == OP_STATUS) ? STAT_LAST : (op_q == OP_READ) ? READ_LAST : WR_LAST;
    assign tick = qcnt_q == 16'(QTR_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // sda sampling and quarter-bit divider

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            {sda_s1_q, sda_s2_q} <= 2'b11;
        end else begin
            {sda_s2_q, sda_s1_q} <= {sda_s1_q, bus.sda};
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || state_q == HS_IDLE || tick) begin
            qcnt_q <= 16'h0000;
        end else begin
            qcnt_q <= qcnt_q + 16'h0001;
        end
    end

    // power-up and post-trigger holdoff; the busy bit must still be checked
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wait_q <= 32'(PWR_CYCLES);
        end else if (done_q && op_q == OP_MEAS && !nak_q) begin
            wait_q <= 32'(MEAS_CYCLES);
        end else if (wait_q != 32'h0000_0000) begin
            wait_q <= wait_q - 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer sequencer: four quarters per bit, scl high in the last two

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_q <= HS_IDLE;
            op_q <= OP_STATUS;
            pend_q <= 1'b0;
            ph_q <= 2'h0;
            k_q <= 3'h0;
            bit_q <= 4'h0;
            tx_q <= 8'h00;
            rx_sh_q <= 8'h00;
            smp_q <= 1'b1;
            nak_q <= 1'b0;
            done_q <= 1'b0;
            nak_ev_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                rx_q[i] <= 8'h00;
            end
        end else begin
            done_q <= 1'b0;
            nak_ev_q <= 1'b0;
            if (reg_wr_in && reg_addr_in == REG_CMD && !pend_q && state_q == HS_IDLE) begin
                pend_q <= 1'b1;
                op_q <= hsc_op_t'(reg_wdata_in[1:0]);
            end
            if (tick) begin
                ph_q <= ph_q + 2'h1;
            end
            case (state_q)
                HS_IDLE: begin
                    if (pend_q && wait_q == 32'h0000_0000) begin
                        pend_q <= 1'b0;
                        nak_q <= 1'b0;
                        ph_q <= 2'h0;
                        state_q <= HS_START;
                    end
                end
                HS_START: begin
                    if (tick && ph_q == 2'h0) begin
                        sda_oe_q <= 1'b1;
                    end else if (tick && ph_q == 2'h1) begin
                        scl_oe_q <= 1'b1;
                        k_q <= 3'h0;
                        bit_q <= 4'h0;
                        tx_q <= tx_byte(op_q, 3'h0);
                        ph_q <= 2'h0;
                        state_q <= HS_BIT;
                    end
                end
                HS_BIT: begin
                    if (tick) begin
                        case (ph_q)
                            2'h0: sda_oe_q <= (bit_q < 4'h8) ? (wr_b & ~tx_q[7])
                                : (~wr_b & (k_q != last_k));
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                smp_q <= sda_s2_q;
                                rx_sh_q <= {rx_sh_q[6:0], sda_s2_q};
                                if (bit_q == 4'h7 && !wr_b) begin
                                    rx_q[k_q - 3'h1] <= {rx_sh_q[6:0], sda_s2_q};
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                tx_q <= {tx_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    if (wr_b && smp_q) begin
                                        nak_q <= 1'b1;
                                        nak_ev_q <= 1'b1;
                                        state_q <= HS_STOP;
                                    end else if (k_q == last_k) begin
                                        state_q <= HS_STOP;
                                    end else begin
                                        k_q <= k_q + 3'h1;
                                        bit_q <= 4'h0;
                                        tx_q <= tx_byte(op_q, k_q + 3'h1);
                                    end
                                end
                            end
                        endcase
                    end
                end
                HS_STOP: begin
                    if (tick && ph_q == 2'h0) begin
                        sda_oe_q <= 1'b1;
                    end else if (tick && ph_q == 2'h1) begin
                        scl_oe_q <= 1'b0;
                    end else if (tick && ph_q == 2'h2) begin
                        sda_oe_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= HS_IDLE;
                    end
                end
                default: state_q <= HS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port and interrupt

    assign irq_ev = {nak_ev_q, done_q};

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            irq_st_q <= 2'b00;
            irq_en_q <= 2'b00;
        end else begin
            // a new event wins over a clear in the same cycle
            if (reg_wr_in && reg_addr_in == REG_IRQ_CLR) begin
                irq_st_q <= (irq_st_q & ~reg_wdata_in[1:0]) | irq_ev;
            end else begin
                irq_st_q <= irq_st_q | irq_ev;
            end
            if (reg_wr_in && reg_addr_in == REG_IRQ_EN) begin
                irq_en_q <= reg_wdata_in[1:0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_addr_in == REG_STAT) begin
            rdata_q <= {20'h0_0000, wait_q != 32'h0000_0000, nak_q,
                pend_q || state_q != HS_IDLE, rx_q[0][ST_BUSY], rx_q[0]};
        end else if (reg_addr_in == REG_DATA0) begin
            rdata_q <= {rx_q[1], rx_q[2], rx_q[3], rx_q[4]};
        end else if (reg_addr_in == REG_DATA1) begin
            rdata_q <= {16'h0000, rx_q[5], rx_q[6]};
        end else if (reg_addr_in == REG_IRQ_STAT) begin
            rdata_q <= {30'h0000_0000, irq_st_q};
        end else if (reg_addr_in == REG_IRQ_EN) begin
            rdata_q <= {30'h0000_0000, irq_en_q};
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out = |(irq_st_q & irq_en_q);
    assign bus.scl_o_host = 1'b0;
    assign bus.scl_oe_host = scl_oe_q;
    assign bus.sda_o_host = 1'b0;
    assign bus.sda_oe_host = sda_oe_q;
endmodule

/* bench/hsc_props.sv */
// checker for the two-wire link between the host and sensor ends
// assumes it sees the resolved wires and the pull-down enables of each end
`timescale 1ns/100ps
module hsc_props (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_host,
    input wire logic sda_oe_host,
    input wire logic sda_o_dev,
    input wire logic sda_oe_dev
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////////////
    a_rst_lines_free: assert property ($fell(sys_rst_in) |-> !sda_oe_dev && !scl_oe_host)
        else $error("link held after reset");
    a_dev_pull_low: assert property (sda_oe_dev |-> !sda_o_dev)
        else $error("sensor drives data high");
    // a data change under a high clock would read as start or stop
    a_dev_edge_lowclk: assert property ($changed(sda_oe_dev) |-> !scl)
        else $error("sensor moved data with clock high");
    a_ack_held: assert property ($rose(sda_oe_dev) |-> sda_oe_dev[*8])
        else $error("acknowledge dropped early");
    a_ack_sampled: assert property ($rose(sda_oe_dev) |-> ##[1:400] $rose(scl))
        else $error("no clock rise over sensor bit");
    a_scl_high_hold: assert property ($rose(scl) |-> scl[*8])
        else $error("clock high too short");
    a_scl_low_hold: assert property ($fell(scl) |-> !scl[*8])
        else $error("clock low too short");
    a_start_by_host: assert property ($fell(sda) && scl |-> sda_oe_host)
        else $error("start not made by host");
    cover property ($rose(sda_oe_dev));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule

/* bench/hsc_tb.sv */
// self-checking bench: host and sensor ends joined, driven over the register port
// assumes short power-up and measurement counts set by parameters
`timescale 1ns/100ps
module hsc_tb
    import hsc_pkg::*;
;
    logic clock_in = 0;
    logic sys_rst_in = 1;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic [31:0] reg_rdata;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic rd_q = 0;
    logic irq;
    logic [1:0] mode = 0;
    logic integ = 0;
    logic [47:0] result = 0;
    logic [63:0] rnd;
    logic busy, init_p, meas_p, ready, bus_bsy;
    int errors = 0;
    int samples_checked = 0;
    int n_init = 0;
    int n_meas = 0;
    int seed = 32'haf2c;
    logic [31:0] exp_q[$];
    logic [7:0] adr_q[$];
    always #12.5 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////////////////
    hsc_if i_hsc_if ();
    hsc_dev #(.SLEEP_CYCLES(50), .MEAS_CYCLES(12000)) i_hsc_dev (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .bus(i_hsc_if.dev), .mode_in(mode), .integ_fail_in(integ),
        .result_in(result), .ready_out(ready), .busy_out(busy), .bus_busy_out(bus_bsy),
        .init_out(init_p), .meas_out(meas_p));
    // host waits longer than the sensor measures, so a read never meets a busy sensor
    hsc_host #(.PWR_CYCLES(50), .MEAS_CYCLES(14000)) i_hsc_host (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .bus(i_hsc_if.host), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .irq_out(irq));
    hsc_props i_hsc_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .scl(i_hsc_if.scl), .sda(i_hsc_if.sda), .scl_oe_host(i_hsc_if.scl_oe_host),
        .sda_oe_host(i_hsc_if.sda_oe_host), .sda_o_dev(i_hsc_if.sda_o_dev),
        .sda_oe_dev(i_hsc_if.sda_oe_dev));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock_in);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        @(posedge clock_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock_in);
        reg_rd <= 1'b0;
    endtask
    // one transfer with the interrupt enabled: wait for done, then clear it
    task op_done(input hsc_op_t op);
        wr(REG_CMD, {30'h0, op});
        for (int i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge clock_in);
        chk(32'(irq), 1, "irq_done");
        rd(REG_IRQ_STAT, 32'h1);
        wr(REG_IRQ_CLR, 32'h1);
        #1 chk(32'(irq), 0, "irq_clear");
    endtask
    always @(posedge clock_in) begin
        rd_q <= reg_rd;
        if (rd_q) chk(reg_rdata, exp_q.pop_front(), $sformatf("reg_%h", adr_q.pop_front()));
        if (init_p === 1'b1) n_init++;
        if (meas_p === 1'b1) n_meas++;
    end
    initial begin
        #(95_000 * CLK_NS);
        errors++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rnd = {$random(seed), $random(seed)};
        sys_rst_in <= 1'b0;
        mode <= rnd[1:0];
        integ <= rnd[2];
        result <= rnd[63:16];
        rd(REG_STAT, 32'h0000_0800);
        rd(REG_IRQ_STAT, 32'h0);
        rd(8'h1c, 32'h0);
        wr(REG_CMD, {30'h0, OP_STATUS});
        repeat (4 * QTR_CYC) @(posedge clock_in);
        chk(32'(ready), 1, "ready");
        chk(32'(bus_bsy), 1, "bus_busy");
        repeat (21 * 4 * QTR_CYC) @(posedge clock_in);
        #1 chk(32'(irq), 0, "irq_masked");
        chk(32'(bus_bsy), 0, "bus_idle");
        rd(REG_IRQ_STAT, 32'h1);
        wr(REG_IRQ_EN, 32'h3);
        #1 chk(32'(irq), 1, "irq_enabled");
        wr(REG_IRQ_CLR, 32'h1);
        rd(REG_STAT, {24'h0, 1'b0, mode, integ, 4'h0});
        $display("status and interrupt test ended");
        op_done(OP_INIT);
        chk(32'(n_init), 1, "init_count");
        op_done(OP_MEAS);
        #1 chk(32'(busy), 1, "busy_meas");
        chk(32'(n_meas), 1, "meas_count");
        repeat (14000) @(posedge clock_in);
        chk(32'(busy), 0, "busy_idle");
        $display("init and measure test ended");
        op_done(OP_READ);
        rd(REG_STAT, {24'h0, 1'b0, mode, integ, 4'h8});
        rd(REG_DATA0, result[47:16]);
        rd(REG_DATA1, {16'h0, result[15:0]});
        repeat (3) @(posedge clock_in);
        $display("read test ended");
        give_verdict;
    end
endmodule
